// ==== dv/audio_clk_checker.sv ====
`timescale 1ns/10ps
module audio_clk_checker
  import audio_clk_pkg::*;
#(
  parameter int MAX_PERIOD = audio_clk_pkg::PER_MAX
) (
  // Clock and reset
  input wire logic                              clk,
  input wire logic                              nrst,
  // APB
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [audio_clk_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                       pwdata,
  input wire logic [31:0]                       prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  // Pins
  input wire logic [audio_clk_pkg::REF_N-1:0]   ref_pin,
  input wire logic                              sample_tick,
  input wire logic                              word_clk_out,
  input wire logic                              split_mode,
  input wire logic                              irq
);
  localparam int GAP_MIN  = PER_MIN_WC;
  // Loss detection plus the slowest master period fits well inside this
  localparam int TICK_MAX = 4 * MAX_PERIOD + 8192;
  logic [16:0] gap_ff;
  logic [15:0] hi_ff;
  wire  [16:0] nxt_gap = sample_tick ? 17'h0 : gap_ff + {16'h0, ~&gap_ff};
  wire  [15:0] nxt_hi  = word_clk_out ? hi_ff + 16'h1 : 16'h0;
  wire         mapped  = (paddr[1:0] == 2'h0) && (paddr <= ADR_IMASK);
  wire         ctrl_wr = psel && penable && pwrite && (paddr == ADR_CTRL);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_ff <= 17'h0;
      hi_ff  <= 16'h0;
    end else begin
      gap_ff <= nxt_gap;
      hi_ff  <= nxt_hi;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_ctrl_split;
    ctrl_wr && pwdata[0] && (pwdata[2:1] == SRC_OPT) && (pwdata[6:4] inside {3'h3, 3'h4});
  endsequence
  sequence s_ctrl_plain;
    ctrl_wr && (pwdata[2:1] != SRC_OPT);
  endsequence
  sequence s_bad_access;
    psel && penable && !mapped;
  endsequence
  property p_tick_pulse; sample_tick |=> !sample_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  property p_tick_gap; sample_tick |-> gap_ff >= 17'(GAP_MIN - 1); endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("runt tick gap");
  property p_tick_alive; gap_ff < 17'(TICK_MAX); endproperty
  a_tick_alive: assert property (p_tick_alive) else $error("sample tick stalled");
  property p_wc_pulse; $fell(word_clk_out) |-> hi_ff == 16'(WC_PULSE); endproperty
  a_wc_pulse: assert property (p_wc_pulse) else $error("word clock pulse width");
  property p_split_on; s_ctrl_split |=> split_mode; endproperty
  a_split_on: assert property (p_split_on) else $error("split not entered");
  property p_split_off; s_ctrl_plain |=> !split_mode; endproperty
  a_split_off: assert property (p_split_off) else $error("split not left");
  property p_split_cause; $changed(split_mode) |-> $past(ctrl_wr); endproperty
  a_split_cause: assert property (p_split_cause) else $error("split moved alone");
  property p_err_map; s_bad_access |-> pslverr && (pwrite || (prdata == 32'h0)); endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_err_phase; pslverr |-> psel && penable && !mapped; endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray slave error");
  property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
endmodule
bind audio_clock_source_select audio_clk_checker #(.MAX_PERIOD(MAX_PERIOD)) chk_u (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ref_pin(ref_pin), .sample_tick(sample_tick), .word_clk_out(word_clk_out),
  .split_mode(split_mode), .irq(irq));

// ==== dv/ref_source_model.sv ====
`timescale 1ns/10ps
module ref_source_model (
  // Clock
  input  wire logic        clk,
  // Period per source in clk cycles, zero when unplugged
  input  wire logic [15:0] period [4],
  // Frame clocks: word, optical, sync, SPDIF
  output logic      [3:0]  ref_pin
);
  for (genvar i = 0; i < 4; i++) begin : g_src
    logic [15:0] cnt_ff;
    logic        pin_ff;
    wire  [15:0] nxt_cnt = (cnt_ff >= period[i] - 16'h1) ? 16'h0 : cnt_ff + 16'h1;
    always_ff @(posedge clk) begin
      cnt_ff <= (period[i] == 16'h0) ? 16'h0 : nxt_cnt;
      // Unplugged source sits low, so no edge can be mistaken for a frame
      pin_ff <= (period[i] != 16'h0) && (nxt_cnt < (period[i] >> 1));
    end
    assign ref_pin[i] = pin_ff;
  end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import audio_clk_pkg::*;
  localparam int          MAXP = 5500;
  localparam logic [31:0] P96  = 32'(CLK_HZ / 96_000);
  localparam logic [31:0] P48  = 32'(CLK_HZ / 48_000);
  logic              clk = 1'b0;
  logic              nrst, psel, penable, pwrite, pready, pslverr, rd_e;
  logic              sample_tick, word_clk_out, split_mode, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd_q, gap_n;
  logic [3:0]        ref_pin;
  logic [15:0]       src_per [4];
  int                fail_count, tests_run;

  always #(CLK_NS / 2) clk = ~clk;

  audio_clock_source_select #(.MAX_PERIOD(MAXP)) dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_pin(ref_pin), .sample_tick(sample_tick), .word_clk_out(word_clk_out),
    .split_mode(split_mode), .irq(irq));
  ref_source_model src (.clk(clk), .period(src_per), .ref_pin(ref_pin));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd_q = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string what);
    xfer(1'b0, a, 32'h0);
    chk(what, e, rd_q & m);
  endtask

  // Cycles between two rises, sampled mid-cycle where outputs have settled
  task automatic gap(input logic use_wc, output logic [31:0] n);
    logic prev, cur;
    int   k, marks;
    prev = 1'b1;
    marks = 0;
    n = 0;
    for (k = 0; k < 20000 && marks < 2; k++) begin
      @(negedge clk);
      cur = use_wc ? word_clk_out : sample_tick;
      if (cur === 1'b1 && prev !== 1'b1) marks++;
      if (marks == 1) n++;
      prev = cur;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (105000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    fail_count = 0;
    tests_run = 0;
    for (int i = 0; i < 4; i++) src_per[i] = 16'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(ADR_CTRL, 32'hffff_ffff, 32'h21, "ctrl");
    rd(ADR_STATUS, 32'h400, 32'h0, "slave at reset");
    rd(ADR_ISTAT, 32'hffff_ffff, 32'h0, "istat");
    rd(ADR_IMASK, 32'hffff_ffff, 32'h0, "imask");
    xfer(1'b1, 8'h40, 32'hffff_ffff);
    chk("write err", 32'h1, {31'h0, rd_e});
    rd(8'h40, 32'hffff_ffff, 32'h0, "unmapped");
    chk("read err", 32'h1, {31'h0, rd_e});
    xfer(1'b1, ADR_IMASK, 32'h7);
    xfer(1'b1, ADR_CTRL, 32'h41);
    gap(1'b0, gap_n);
    gap(1'b0, gap_n);
    chk("master tick", P96, gap_n);
    gap(1'b1, gap_n);
    chk("word out", P96, gap_n);
    src_per[0] <= P96[15:0];
    src_per[3] <= P96[15:0];
    xfer(1'b1, ADR_CTRL, 32'h49);
    for (int i = 0; i < 3; i++) gap(1'b1, gap_n);
    chk("word out halved", P48, gap_n);
    rd(ADR_STATUS, 32'hfff, 32'h482, "slave on word");
    rd(ADR_ACTPER, 32'hffff, P96, "active period");
    rd(ADR_SPDPER, 32'hffff, P96, "spdif period");
    rd(ADR_ISTAT, 32'h1, 32'h1, "source event");
    @(negedge clk);
    chk("irq set", 32'h1, {31'h0, irq});
    xfer(1'b1, ADR_ISTAT, 32'h7);
    @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b1, ADR_IMASK, 32'h0);
    src_per[0] <= 16'h0;
    src_per[1] <= 16'd3000;
    repeat (10000) @(posedge clk);
    rd(ADR_STATUS, 32'hfff, 32'h784, "fallback");
    @(negedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, ADR_IMASK, 32'h1);
    @(negedge clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    src_per[0] <= P96[15:0];
    repeat (9000) @(posedge clk);
    rd(ADR_STATUS, 32'hfff, 32'h486, "preferred back");
    xfer(1'b1, ADR_CTRL, 32'h43);
    @(negedge clk);
    chk("split pin", 32'h1, {31'h0, split_mode});
    src_per[1] <= P48[15:0];
    repeat (16000) @(posedge clk);
    rd(ADR_STATUS, 32'hfff, 32'hd8a, "split status");
    rd(ADR_SPDPER, 32'hffff, P96, "split spdif");
    rd(ADR_ACTPER, 32'hffff, 2 * P96, "split optical");
    xfer(1'b1, ADR_CTRL, 32'h40);
    repeat (4000) @(posedge clk);
    rd(ADR_STATUS, 32'h400, 32'h0, "master mode");
    xfer(1'b1, ADR_CTRL, 32'h41);
    repeat (4000) @(posedge clk);
    xfer(1'b1, ADR_ISTAT, 32'h7);
    for (int i = 0; i < 4; i++) src_per[i] <= 16'h0;
    repeat (10000) @(posedge clk);
    rd(ADR_STATUS, 32'h4ff, 32'h0, "all lost");
    rd(ADR_ISTAT, 32'h2, 32'h2, "fell to master");
    finish_test();
  end
endmodule

// ==== src/audio_clk_pkg.sv ====
package audio_clk_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_NS = 4;
  localparam int REF_N  = 4;
  localparam int PER_W  = 16;
  localparam int ADDR_W = 8;
  localparam int IRQ_W  = 3;

  // Source indices, also the scan order
  localparam logic [1:0] SRC_WORD  = 2'h0;
  localparam logic [1:0] SRC_OPT   = 2'h1;
  localparam logic [1:0] SRC_OSYNC = 2'h2;
  localparam logic [1:0] SRC_SPDIF = 2'h3;

  localparam int RANGE_MIN_HZ = 28_000;
  localparam int RATE_MAX_HZ  = 103_000;
  localparam int WC_MAX_HZ    = 105_000;
  // Longest period rounds down, shortest rounds up
  localparam int PER_MAX      = CLK_HZ / RANGE_MIN_HZ;
  localparam int PER_MIN_RATE = (CLK_HZ + RATE_MAX_HZ - 1) / RATE_MAX_HZ;
  localparam int PER_MIN_WC   = (CLK_HZ + WC_MAX_HZ - 1) / WC_MAX_HZ;
  localparam int SYNC_TOL     = 16;
  localparam int WC_PULSE     = PER_MIN_WC / 2;

  localparam logic [1:0] LK_NONE = 2'h0;
  localparam logic [1:0] LK_LOCK = 2'h1;
  localparam logic [1:0] LK_SYNC = 2'h2;

  typedef enum logic [2:0] {
    RATE_32  = 3'b000,
    RATE_441 = 3'b001,
    RATE_48  = 3'b010,
    RATE_882 = 3'b011,
    RATE_96  = 3'b100
  } rate_e;

  localparam logic [ADDR_W-1:0] ADR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_ACTPER = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_SPDPER = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_ISTAT  = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_IMASK  = 8'h14;

  localparam int CTRL_AUTO    = 0;
  localparam int CTRL_PREF    = 1;
  localparam int CTRL_SINGLE  = 3;
  localparam int CTRL_RATE    = 4;
  localparam logic [6:0] CTRL_RST = 7'h21;
  localparam int ST_SRC       = 8;
  localparam int ST_SLAVE     = 10;
  localparam int ST_SPLIT     = 11;
  localparam int IRQ_SRC      = 0;
  localparam int IRQ_MASTER   = 1;
  localparam int IRQ_LOCK     = 2;

  function automatic logic [PER_W-1:0] rate_period(input rate_e r);
    case (r)
      RATE_32:  rate_period = PER_W'(CLK_HZ / 32_000);
      RATE_441: rate_period = PER_W'(CLK_HZ / 44_100);
      RATE_48:  rate_period = PER_W'(CLK_HZ / 48_000);
      RATE_882: rate_period = PER_W'(CLK_HZ / 88_200);
      RATE_96:  rate_period = PER_W'(CLK_HZ / 96_000);
      default:  rate_period = PER_W'(CLK_HZ / 48_000);
    endcase
  endfunction
endpackage

// ==== src/audio_clock_source_select.sv ====
// How it works
// - Word clock out follows sample rate; halved mode halves any rate above 48 kHz.
// - Clock mode picks master crystal or automatic mode from preferred source.
// - Invalid preferred source makes the device move to the next available one.
// - Automatic selection considers word clock, optical, sync and SPDIF inputs.
// - Automatic mode scans inputs; valid input at playback rate becomes clock.
// - System clock state reads as master or slave.
// - Valid preferred input stays source; otherwise remaining inputs scanned in turn.
// - No valid candidate forces master mode on the internal crystal.
// - Only one reference clocks the device: first valid input found.
// - Each input reports no lock, lock or sync.
// - Active source is reported with its period: measured when slave, crystal divider period when master.
// - Any rate from 28 to 103 kHz is accepted and locked.
// - Word clock input accepts 28 to 105 kHz for varispeed.
// - Optical preferred at 88.2/96 kHz enters split mode at half rate.
// - In split mode the optical rate reads half the SPDIF rate.
// - SPDIF measured rate is a separate status value.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module audio_clock_source_select #(
  parameter int MAX_PERIOD = audio_clk_pkg::PER_MAX
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              nrst,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [audio_clk_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Recovered frame clocks: word, optical, sync, SPDIF
  input  wire logic [audio_clk_pkg::REF_N-1:0]   ref_pin,
  // System sample clock and word clock out
  output logic                                   sample_tick,
  output logic                                   word_clk_out,
  // Status pins
  output logic                                   split_mode,
  output logic                                   irq
);
  import audio_clk_pkg::*;

  function automatic logic period_match(input logic [PER_W-1:0] p,
                                        input logic [PER_W-1:0] t);
    logic [PER_W-1:0] d;
    d = (p > t) ? p - t : t - p;
    period_match = d <= PER_W'(SYNC_TOL);
  endfunction

  // Returns {found, index}, scanning from the preferred input onward
  function automatic logic [2:0] first_from(input logic [3:0] elig,
                                            input logic [1:0] pref);
    logic [1:0] idx;
    first_from = 3'h0;
    for (int k = REF_N - 1; k >= 0; k--) begin
      idx = pref + 2'(k);
      if (elig[idx])
        first_from = {1'b1, idx};
    end
  endfunction

  // Control register and internal state
  logic [6:0]        ctrl_ff;
  logic [IRQ_W-1:0]  istat_ff;
  logic [IRQ_W-1:0]  imask_ff;
  logic [31:0]       prdata_ff;
  logic [PER_W-1:0]  mcnt_ff;
  logic              half_ff;
  logic [PER_W-1:0]  wcnt_ff;
  logic              wc_ff;
  logic [7:0]        lock_prev_ff;
  logic              slave_prev_ff;
  logic [1:0]        src_prev_ff;
  logic [PER_W-1:0]  act_per_ff;

  wire        auto_mode = ctrl_ff[CTRL_AUTO];
  wire [1:0]  pref_src  = ctrl_ff[CTRL_PREF +: 2];
  wire        single_sp = ctrl_ff[CTRL_SINGLE];
  wire rate_e rate_sel  = rate_e'(ctrl_ff[CTRL_RATE +: 3]);

  // Input measurement
  logic [REF_N-1:0]  ref_tick;
  logic [REF_N-1:0]  ref_valid;
  logic [PER_W-1:0]  ref_per [REF_N];

  for (genvar i = 0; i < REF_N; i++) begin : g_meter
    rate_meter #(
      .MIN_P (i == 0 ? PER_MIN_WC : PER_MIN_RATE),
      .MAX_P (MAX_PERIOD)
    ) u_meter (
      .clk    (clk),
      .nrst   (nrst),
      .pin    (ref_pin[i]),
      .tick   (ref_tick[i]),
      .valid  (ref_valid[i]),
      .period (ref_per[i])
    );
  end

  // Rates
  wire             dbl_rate  = (rate_sel == RATE_882) || (rate_sel == RATE_96);
  // Only the optical multichannel input forces split; the sync input does not
  wire             pref_opt  = pref_src == SRC_OPT;
  wire             split     = dbl_rate && auto_mode && pref_opt;
  wire [PER_W-1:0] base_per  = rate_period(rate_sel);
  // internal rate halves in split mode
  wire [PER_W-1:0] mast_per  = split ? PER_W'(base_per << 1) : base_per;
  // optical streams run at half the SPDIF rate
  wire [PER_W-1:0] opt_tgt   = split ? PER_W'(base_per << 1) : base_per;

  // Per-input status
  logic [REF_N-1:0] ref_sync;
  logic [7:0]       lock_vec;
  always_comb begin
    for (int i = 0; i < REF_N; i++) begin
      ref_sync[i] = ref_valid[i] &&
        period_match(ref_per[i], (i == 1 || i == 2) ? opt_tgt : base_per);
      lock_vec[2*i +: 2] = !ref_valid[i] ? LK_NONE :
                           ref_sync[i]   ? LK_SYNC : LK_LOCK;
    end
  end

  // Source selection
  // candidates are the four inputs at the playback rate
  wire [2:0] pick       = first_from(ref_sync, pref_src);
  // master unless auto mode finds a valid input
  wire       want_slave = auto_mode && pick[2];
  // preferred first, then the others in turn
  wire [1:0] want_src   = pick[1:0];

  logic       cur_slave;
  logic [1:0] cur_src;
  logic       sw_tick;

  // Internal crystal divider
  wire master_tick = (mcnt_ff >= mast_per - 16'h0001);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      mcnt_ff <= 16'h0000;
    else if (master_tick)
      mcnt_ff <= 16'h0000;
    else
      mcnt_ff <= mcnt_ff + 16'h0001;
  end

  clk_switch #(
    .GAP_MIN (PER_MIN_WC)
  ) u_switch (
    .clk         (clk),
    .nrst        (nrst),
    .master_tick (master_tick),
    .ref_tick    (ref_tick),
    .want_slave  (want_slave),
    .want_src    (want_src),
    .tick        (sw_tick),
    .cur_slave   (cur_slave),
    .cur_src     (cur_src)
  );

  // Word clock out
  // Fast means above 48 kHz; in split mode the master, optical and sync ticks are already halved, word and SPDIF ticks are not
  wire fast    = act_per_ff < (rate_period(RATE_48) - PER_W'(SYNC_TOL));
  // halve only when single speed is asked and the rate is high
  wire halve   = single_sp && fast;
  wire wc_fire = sw_tick && (!halve || half_ff);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_ff <= 1'b0;
      wcnt_ff <= 16'h0000;
      wc_ff   <= 1'b0;
    end else begin
      if (sw_tick)
        half_ff <= ~half_ff;
      if (wc_fire) begin
        wcnt_ff <= PER_W'(WC_PULSE);
        wc_ff   <= 1'b1;
      end else if (wcnt_ff != 16'h0000) begin
        wcnt_ff <= wcnt_ff - 16'h0001;
        wc_ff   <= wcnt_ff != 16'h0001;
      end else begin
        wc_ff   <= 1'b0;
      end
    end
  end

  // Active source period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      act_per_ff <= 16'h0000;
    // period of the source actually in use
    else if (cur_slave)
      act_per_ff <= ref_per[cur_src];
    else
      act_per_ff <= mast_per;
  end

  // Events
  wire ev_src    = (cur_slave != slave_prev_ff) ||
                   (cur_slave && cur_src != src_prev_ff);
  wire ev_master = slave_prev_ff && !cur_slave;
  wire ev_lock   = lock_vec != lock_prev_ff;
  wire [IRQ_W-1:0] ev = {ev_lock, ev_master, ev_src};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_prev_ff  <= 8'h00;
      slave_prev_ff <= 1'b0;
      src_prev_ff   <= 2'h0;
    end else begin
      lock_prev_ff  <= lock_vec;
      slave_prev_ff <= cur_slave;
      src_prev_ff   <= cur_src;
    end
  end

  // APB decode
  wire        acc     = psel && penable;
  wire        setup   = psel && !penable;
  wire        hit_ctl = paddr == ADR_CTRL;
  wire        hit_st  = paddr == ADR_STATUS;
  wire        hit_ap  = paddr == ADR_ACTPER;
  wire        hit_sp  = paddr == ADR_SPDPER;
  wire        hit_is  = paddr == ADR_ISTAT;
  wire        hit_im  = paddr == ADR_IMASK;
  wire        mapped  = hit_ctl | hit_st | hit_ap | hit_sp | hit_is | hit_im;
  wire        wr      = acc && pwrite && mapped;
  wire [IRQ_W-1:0] w1c = (wr && hit_is) ? pwdata[IRQ_W-1:0] : '0;

  wire [31:0] status_w = {20'h00000, split, cur_slave, cur_src, lock_vec};

  wire [31:0] rd_mux = hit_ctl ? {25'h0000000, ctrl_ff} :
                       hit_st  ? status_w :
                       hit_ap  ? {16'h0000, act_per_ff} :
                       hit_sp  ? {16'h0000, ref_per[SRC_SPDIF]} :
                       hit_is  ? {29'h00000000, istat_ff} :
                       hit_im  ? {29'h00000000, imask_ff} : 32'h00000000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff  <= CTRL_RST;
      imask_ff <= '0;
    end else if (wr && hit_ctl) begin
      ctrl_ff  <= pwdata[6:0];
    end else if (wr && hit_im) begin
      imask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // New events win over a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      istat_ff <= '0;
    else
      istat_ff <= (istat_ff & ~w1c) | ev;
  end

  // Read data is captured in setup so access completes with no wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      prdata_ff <= 32'h00000000;
    else if (setup && !pwrite)
      prdata_ff <= rd_mux;
  end

  assign prdata       = prdata_ff;
  assign pready       = 1'b1;
  assign pslverr      = acc && !mapped;
  assign sample_tick  = sw_tick;
  assign word_clk_out = wc_ff;
  assign split_mode   = split;
  assign irq          = |(istat_ff & imask_ff);
endmodule

// ==== src/clk_switch.sv ====
`timescale 1ns/10ps
module clk_switch #(
  parameter int GAP_MIN = 2381
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Candidate ticks
  input  wire logic       master_tick,
  input  wire logic [3:0] ref_tick,
  // Requested source
  input  wire logic       want_slave,
  input  wire logic [1:0] want_src,
  // Switched tick and current source
  output logic            tick,
  output logic            cur_slave,
  output logic [1:0]      cur_src
);
  logic        slave_ff;
  logic [1:0]  src_ff;
  logic [15:0] gap_ff;
  wire gap_ok   = gap_ff >= 16'(GAP_MIN);
  wire changing = (want_slave != slave_ff) || (want_slave && want_src != src_ff);
  wire cur_tick = slave_ff ? ref_tick[src_ff] : master_tick;
  wire req_tick = want_slave ? ref_tick[want_src] : master_tick;
  // Old source is muted while a change is pending; the new one is
  // only let through after a full minimum period, so no runt tick.
  wire adopt    = changing && req_tick && gap_ok;
  wire out_tick = changing ? adopt : cur_tick;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slave_ff <= 1'b0;
      src_ff   <= 2'h0;
      gap_ff   <= 16'h0000;
    end else begin
      if (adopt) begin
        slave_ff <= want_slave;
        src_ff   <= want_src;
      end
      if (out_tick)
        gap_ff <= 16'h0001;
      else if (!gap_ok)
        gap_ff <= gap_ff + 16'h0001;
    end
  end

  assign tick      = out_tick;
  assign cur_slave = slave_ff;
  assign cur_src   = src_ff;
endmodule

// ==== src/rate_meter.sv ====
`timescale 1ns/10ps
module rate_meter #(
  parameter int MIN_P = 2381,
  parameter int MAX_P = 8928
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Recovered frame clock pin
  input  wire logic        pin,
  // Measurement
  output logic             tick,
  output logic             valid,
  output logic [15:0]      period
);
  logic s1_ff, s2_ff, s3_ff;
  logic [15:0] cnt_ff;
  logic        valid_ff;
  logic [15:0] period_ff;
  wire         rise    = s2_ff & ~s3_ff;
  wire         over    = cnt_ff > 16'(MAX_P);
  wire         in_rng  = (cnt_ff >= 16'(MIN_P)) && !over;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Counter saturates so a dead input reads as out of range
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff    <= 16'hffff;
      valid_ff  <= 1'b0;
      period_ff <= 16'h0000;
    end else if (rise) begin
      cnt_ff    <= 16'h0001;
      valid_ff  <= in_rng;
      period_ff <= cnt_ff;
    end else begin
      if (!over)
        cnt_ff <= cnt_ff + 16'h0001;
      if (over)
        valid_ff <= 1'b0;
    end
  end

  assign tick   = rise;
  assign valid  = valid_ff;
  assign period = period_ff;
endmodule
